/* File: include/scp_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_ADDR_DATA 8'h21
`define SCP_ADDR_CTRL 8'h22
`define SCP_ADDR_CSR 8'h23
`define SCP_CR_IRQEN 7
`define SCP_CR_PEN 6
`define SCP_CR_DIV2 5
`define SCP_CR_CTRL 4
`define SCP_CR_CLK_IDLE_LEVEL 3
`define SCP_CR_CLK_CAPTURE_PHASE 2
`define SCP_SR_DONE 7
`define SCP_SR_WRITE_COLLISION_FLAG 6
`define SCP_SR_OVR 5
`define SCP_SR_FAULT 4
`define SCP_SR_SOD 2
`define SCP_SR_SSM 1
`define SCP_SR_SSI 0
`define SCP_CR_RESET 8'h00
`define SCP_SR_RESET 8'h00
`define SCP_CR_SW_MASK 8'hFF
`define SCP_SR_SW_MASK 8'h07
`define SCP_BITS 4'h8
`define SCP_DIV_W 7
`endif

/* File: include/scp_pkg.sv */
// types shared by the serial port
package scp_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scp_bus_t;
   typedef struct packed {
      logic o;
      logic oe;
   } scp_pin_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LEAD,
      ST_TRAIL
   } scp_state_t;
endpackage

/* File: rtl/scp_core.sv */
// serial peripheral port: registers, clock divider, shifter, pins
`include "scp_params.svh"
`default_nettype none
// Overview of operation
// (RQ1) irq when enabled and done, overrun or fault flag
// (RQ2) port enable resets low, cleared by fault
// (RQ3) controller select drives sck, swaps data pins
// (RQ4) idle level sets resting sck level
// (RQ5) phase picks first or second capture edge
// (RQ6) rate bits divide clock 4 to 128
// (RQ7) rate bits ignored in target mode
// (RQ8) software disables port before idle change
// (RQ9) far target matches idle and phase
// (RQ10) done set at end, csr then data clears
// (RQ11) data writes ignored while done pending
// (RQ12) write during transfer flags collision only
// (RQ13) overrun when byte lands while done set
// (RQ14) fault on low select, csr+ctrl clears
// (RQ15) software writes zero to reserved bit
// (RQ16) output disable gates data output pin
// (RQ17) soft management takes select from bit
// (RQ18) soft level zero means selected
// (RQ19) controller data write starts one byte
// (RQ20) received byte copied to read buffer
// (RQ21) register addresses and reset values
// (RQ22) fault clears enable and controller select
// (RQ23) overrun keeps earlier byte, drops later
// (RQ24) eight bits msb first both ways
module scp_core (
   input wire logic MCLK,
   input wire logic NRST,
   input wire scp_pkg::scp_bus_t BUS,
   output logic [7:0] RDATA,
   output logic IRQ,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE,
   input wire logic SS_N_I
);
   import scp_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [2:0] sync3_ff;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         // idle pin levels, so no false clock edge follows reset
         sync1_ff <= 3'h5;
         sync2_ff <= 3'h5;
         sync3_ff <= 3'h5;
      end else begin
         sync1_ff <= {SS_N_I, SCK_I, MOSI_I ^ MISO_I ^ MISO_I};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end
   logic [1:0] din1_ff;
   logic [1:0] din2_ff;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         din1_ff <= 2'h0;
         din2_ff <= 2'h0;
      end else begin
         din1_ff <= {MOSI_I, MISO_I};
         din2_ff <= din1_ff;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] ctrl_ff;
   logic [2:0] csr_sw_ff;
   logic done_ff;
   logic write_collision_flag_ff;
   logic ovr_ff;
   logic fault_ff;
   logic [7:0] rbuf_ff;
   logic [7:0] shift_ff;
   logic csr_seen_ff;
   logic fault_seen_ff;
   scp_state_t state_ff;
   wire sel_data = (BUS.addr == `SCP_ADDR_DATA);
   wire sel_ctrl = (BUS.addr == `SCP_ADDR_CTRL);
   wire sel_csr = (BUS.addr == `SCP_ADDR_CSR);
   wire wr_data = BUS.wr && sel_data;
   wire wr_ctrl = BUS.wr && sel_ctrl;
   wire wr_csr = BUS.wr && sel_csr;
   wire rd_data = BUS.rd && sel_data;
   wire rd_csr = BUS.rd && sel_csr;
   wire pen = ctrl_ff[`SCP_CR_PEN];
   wire ctl_mode = ctrl_ff[`SCP_CR_CTRL];
   wire clk_idle_level = ctrl_ff[`SCP_CR_CLK_IDLE_LEVEL];
   wire clk_capture_phase = ctrl_ff[`SCP_CR_CLK_CAPTURE_PHASE];
   wire output_disable_bit = csr_sw_ff[`SCP_SR_SOD];
   wire select_soft_mgmt = csr_sw_ff[`SCP_SR_SSM];
   wire select_soft_level = csr_sw_ff[`SCP_SR_SSI];
   // internal select: pin or soft level, low means selected
   wire sel_n = select_soft_mgmt ? select_soft_level : sync2_ff[2]; // RQ17 RQ18
   wire fault_ev = pen && ctl_mode && !sel_n; // RQ14
   wire busy = (state_ff != ST_IDLE);
   // done clear: csr read then data access
   wire done_clr = csr_seen_ff && (rd_data || wr_data); // RQ10
   // writes blocked while done pending and csr not yet read
   wire wr_blocked = done_ff && !csr_seen_ff; // RQ11
   wire wr_ok = wr_data && !wr_blocked && !busy;
   wire write_collision_flag_ev = wr_data && busy; // RQ12
   wire fault_clr = fault_seen_ff && wr_ctrl; // RQ14
   ////////////////////////////////////////////////////////////////////
   // clock divider, controller mode only
   logic [`SCP_DIV_W-1:0] div_ff;
   logic [`SCP_DIV_W-1:0] half;
   always_comb begin
      half = 7'h01;
      case ({ctrl_ff[1], ctrl_ff[0]})
         2'b00: half = ctrl_ff[`SCP_CR_DIV2] ? 7'h02 : 7'h04; // RQ6
         2'b01: half = 7'h08;
         2'b10: half = ctrl_ff[`SCP_CR_DIV2] ? 7'h10 : 7'h20;
         2'b11: half = 7'h40;
         default: half = 7'h01;
      endcase
      if (!ctrl_ff[1] && ctrl_ff[0] && ctrl_ff[`SCP_CR_DIV2]) begin
         half = 7'h08;
      end
   end
   // 1,_,1 is undefined; treated as /16 or /128
   // limitation: at /4 a reply bit through the pin sync lands late
   wire div_end = (div_ff == half - 7'h01);
   wire tick = ctl_mode && busy && div_end; // RQ7
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         div_ff <= '0;
      end else if (!busy || !ctl_mode || div_end) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 7'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // target edge detection
   wire sck_rise = sync2_ff[1] && !sync3_ff[1];
   wire sck_fall = !sync2_ff[1] && sync3_ff[1];
   wire t_edge = !ctl_mode && pen && !sel_n && (sck_rise || sck_fall);
   wire edge_ev = ctl_mode ? tick : t_edge;
   // first transition is leading edge relative to idle level
   wire din = ctl_mode ? din2_ff[0] : din2_ff[1]; // RQ3
   ////////////////////////////////////////////////////////////////////
   // shifter
   logic [3:0] cnt_ff;
   logic sample_ff;
   logic tx_hold_ff;
   logic sck_ff;
   scp_state_t nxt_state;
   logic start;
   assign start = (ctl_mode && wr_ok) ||
                  (!ctl_mode && pen && !sel_n && !busy && t_edge); // RQ19
   wire last = busy && edge_ev && state_ff == ST_TRAIL &&
               cnt_ff == `SCP_BITS - 4'h1;
   wire capture_lead = !clk_capture_phase; // RQ5
   // an idle target takes its first selected edge as the leading one
   wire edge_go = edge_ev && (busy || start);
   wire in_lead = (state_ff != ST_TRAIL);
   wire cap_ev = edge_go && (in_lead == capture_lead); // RQ5
   wire shf_ev = edge_go && (in_lead != capture_lead); // RQ5
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (start) nxt_state = ctl_mode ? ST_LEAD : ST_TRAIL;
         ST_LEAD: if (edge_ev) nxt_state = ST_TRAIL;
         ST_TRAIL: if (edge_ev) nxt_state = last ? ST_IDLE : ST_LEAD;
         default: nxt_state = ST_IDLE;
      endcase
      if (!pen) nxt_state = ST_IDLE;
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         cnt_ff <= 4'h0;
      end else if (start) begin
         cnt_ff <= 4'h0;
      end else if (edge_go && !in_lead) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sample_ff <= 1'b0;
      end else if (cap_ev) begin
         sample_ff <= din; // RQ24
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         shift_ff <= 8'h00;
      end else if (wr_ok) begin
         shift_ff <= BUS.wdata; // RQ19
      end else if (shf_ev) begin
         shift_ff <= {shift_ff[6:0], sample_ff}; // RQ24
      end
   end
   // phase 1: the bit on the wire is held while the shifter moves on
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         tx_hold_ff <= 1'b0;
      end else if (shf_ev) begin
         tx_hold_ff <= shift_ff[7];
      end
   end
   // with phase 0 the final shift happens on the last trailing edge
   wire [7:0] rx_byte = capture_lead ? {shift_ff[6:0], sample_ff} :
                        {shift_ff[6:0], din};
   ////////////////////////////////////////////////////////////////////
   // flags and control register
   logic [7:0] nxt_ctrl;
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = BUS.wdata & `SCP_CR_SW_MASK;
      end
      // enable and controller stay low until the fault is cleared
      if (fault_ev || (wr_ctrl && fault_ff && !fault_clr)) begin
         nxt_ctrl[`SCP_CR_PEN] = 1'b0; // RQ2 RQ22
         nxt_ctrl[`SCP_CR_CTRL] = 1'b0; // RQ3 RQ22
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_ff <= `SCP_CR_RESET; // RQ21
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         csr_sw_ff <= 3'h0;
      end else if (wr_csr) begin
         csr_sw_ff <= BUS.wdata[2:0];
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         csr_seen_ff <= 1'b0;
      end else if (rd_csr) begin
         csr_seen_ff <= 1'b1;
      end else if (rd_data || wr_data) begin
         csr_seen_ff <= 1'b0;
      end
   end
   // set wins over clear for each flag
   wire rbuf_load = last && (!done_ff || done_clr);
   wire ovr_set = last && done_ff && !done_clr;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         done_ff <= 1'b0;
      end else if (last) begin
         done_ff <= 1'b1; // RQ10
      end else if (done_clr) begin
         done_ff <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rbuf_ff <= 8'h00;
      end else if (rbuf_load) begin
         rbuf_ff <= rx_byte; // RQ20 RQ23
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         ovr_ff <= 1'b0;
      end else if (ovr_set) begin
         ovr_ff <= 1'b1; // RQ13 RQ23
      end else if (rd_csr) begin
         ovr_ff <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         write_collision_flag_ff <= 1'b0;
      end else if (write_collision_flag_ev) begin
         write_collision_flag_ff <= 1'b1; // RQ12
      end else if (done_clr) begin
         write_collision_flag_ff <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         fault_ff <= 1'b0;
      end else if (fault_ev) begin
         fault_ff <= 1'b1; // RQ14
      end else if (fault_clr) begin
         fault_ff <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         fault_seen_ff <= 1'b0;
      end else if (rd_csr && fault_ff) begin
         fault_seen_ff <= 1'b1;
      end else if (wr_ctrl) begin
         fault_seen_ff <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // read data, irq and pins
   wire [7:0] csr_val = {done_ff, write_collision_flag_ff, ovr_ff, fault_ff, 1'b0,
                         csr_sw_ff}; // RQ15
   wire [7:0] rd_mux = sel_data ? rbuf_ff :
                       sel_ctrl ? ctrl_ff :
                       sel_csr ? csr_val : 8'h00;
   wire irq_nxt = ctrl_ff[`SCP_CR_IRQEN] &&
                  (done_ff || ovr_ff || fault_ff); // RQ1
   // sck toggles on each tick, rests at idle level
   wire sck_nxt = busy && ctl_mode ? (tick ? !sck_ff : sck_ff) : clk_idle_level;
   wire out_bit = (busy && !capture_lead) ? tx_hold_ff : shift_ff[7];
   wire dout_en = pen && !output_disable_bit; // RQ16
   wire mosi_en = dout_en && ctl_mode; // RQ16
   wire miso_en = dout_en && !ctl_mode && !sel_n; // RQ16
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 8'h00;
         IRQ <= 1'b0;
      end else begin
         RDATA <= BUS.rd ? rd_mux : 8'h00;
         IRQ <= irq_nxt;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sck_ff <= 1'b0;
         SCK_O <= 1'b0;
         SCK_OE <= 1'b0;
      end else begin
         sck_ff <= sck_nxt; // RQ4
         SCK_O <= sck_nxt;
         SCK_OE <= pen && ctl_mode; // RQ2 RQ3
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         MOSI_O <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_O <= 1'b0;
         MISO_OE <= 1'b0;
      end else begin
         MOSI_O <= out_bit;
         MOSI_OE <= mosi_en;
         MISO_O <= out_bit;
         MISO_OE <= miso_en;
      end
   end
endmodule
`default_nettype wire

/* File: tb/scp_core_chk.sv */
// assertions on the serial port bus and pins
`default_nettype none
module scp_core_chk (
   input wire logic MCLK,
   input wire logic NRST,
   input wire scp_pkg::scp_bus_t BUS,
   input wire logic [7:0] RDATA,
   input wire logic IRQ,
   input wire logic SCK_O,
   input wire logic SCK_OE,
   input wire logic MOSI_OE,
   input wire logic MISO_OE
);
   import scp_pkg::*;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);
   wire logic wc = BUS.wr && BUS.addr == 8'h22;
   wire logic rc = BUS.rd && BUS.addr == 8'h22;
   wire logic ws = BUS.wr && BUS.addr == 8'h23;
   wire logic rs = BUS.rd && BUS.addr == 8'h23;
   wire logic hit = BUS.addr inside {8'h21, 8'h22, 8'h23};
   ////////////////////////////////////////////////////////////////////
   rd_quiet_a: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (BUS.rd && !hit |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   ctrl_rdback_a: assert property (wc ##2 rc |=>
      (RDATA & 8'hAF) == ($past(BUS.wdata, 3) & 8'hAF))
      else $error("control read back differs");
   csr_rdback_a: assert property (ws ##2 rs |=>
      RDATA[3:0] == {1'b0, $past(BUS.wdata[2:0], 3)})
      else $error("status soft bits read back differ");
   mosi_ctrl_a: assert property (MOSI_OE |-> SCK_OE)
      else $error("data out driven outside controller mode");
   miso_tgt_a: assert property (MISO_OE |-> !SCK_OE)
      else $error("target data out driven in controller mode");
   sck_half_a: assert property (
      SCK_OE && $past(SCK_OE) && $changed(SCK_O) |=> $stable(SCK_O))
      else $error("serial clock half period below two cycles");
   irq_off_a: assert property (wc && !BUS.wdata[7] ##1 !wc |=> !IRQ)
      else $error("request high while disabled");
   cover property ($rose(IRQ));
   cover property ($rose(MISO_OE));
   cover property (SCK_OE && $changed(SCK_O));
endmodule
`default_nettype wire

/* File: tb/scp_peer.sv */
// serial target model facing the port in controller mode
`default_nettype none
module scp_peer (
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic clk_idle_level,
   input wire logic clk_capture_phase,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   logic out = 1'b0;
   logic lead;
   // released line shows the inverse, never a stale level
   assign miso = ss_n ? ~out : out;
   always @(negedge ss_n) begin
      sh = clk_capture_phase ? tx : tx << 1;
      out = clk_capture_phase ? ~tx[7] : tx[7];
   end
   always @(sck) begin
      lead = sck != clk_idle_level;
      if (!ss_n && lead != clk_capture_phase) rx = {rx[6:0], mosi};
      else if (!ss_n) begin
         out = sh[7];
         sh = sh << 1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/scp_core_tb.sv */
// self-checking bench for the serial port
`default_nettype none
module scp_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scp_pkg::*;
   logic MCLK = 0, NRST = 0, SCK_I = 0, MOSI_I = 0, SS_N_I = 1;
   logic clk_idle_level = 0, clk_capture_phase = 0, ss_n = 1;
   logic [7:0] ptx = 8'h00, r, m, RDATA, prx;
   logic IRQ, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE, miso;
   scp_bus_t BUS = '0;
   wire logic sck_w = SCK_OE ? SCK_O : clk_idle_level;
   wire logic mosi_w = MOSI_OE ? MOSI_O : ~MOSI_O;
   int errors = 0, n_tests = 0;
   logic [24:0] tbl [10] = '{
      {8'h00, 9'h022, 8'h00}, {8'h00, 9'h023, 8'h00},
      {8'h00, 9'h021, 8'h00}, {8'h00, 9'h030, 8'h00},
      {8'h00, 9'h122, 8'hAF}, {8'hAF, 9'h022, 8'h00},
      {8'h00, 9'h122, 8'h00}, {8'h00, 9'h123, 8'hFF},
      {8'h07, 9'h023, 8'h00}, {8'h00, 9'h123, 8'h00}};
   logic [8:0] so [3] = '{9'h102, 9'h003, 9'h006};
   scp_core i_dut (.MCLK, .NRST, .BUS, .RDATA, .IRQ, .SCK_I, .SCK_O,
      .SCK_OE, .MOSI_I, .MOSI_O, .MOSI_OE, .MISO_I(miso), .MISO_O,
      .MISO_OE, .SS_N_I);
   scp_peer i_peer (.sck(sck_w), .mosi(mosi_w), .ss_n, .clk_idle_level, .clk_capture_phase,
      .tx(ptx), .miso, .rx(prx));
   initial forever #4 MCLK = ~MCLK;
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge MCLK);
      BUS <= '{a, d, w, !w};
      @(posedge MCLK);
      BUS <= '0;
      #1 r = RDATA;
   endtask
   task automatic wirq();
      int i;
      for (i = 0; i < 3000 && IRQ !== 1'b1; i++) @(posedge MCLK);
      chk({7'h0, IRQ}, 8'h01);
   endtask
   // far controller on the link pins, idle low, first edge captures
   task automatic ext(input logic [7:0] t);
      for (int i = 7; i >= 0; i--) begin
         MOSI_I <= t[i];
         repeat (4) @(posedge MCLK);
         SCK_I <= 1'b1;
         #1 r[i] = MISO_O;
         repeat (4) @(posedge MCLK);
         SCK_I <= 1'b0;
      end
      repeat (4) @(posedge MCLK);
   endtask
   task automatic summarize();
      if (errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      errors++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge MCLK);
      NRST <= 1'b1;
      foreach (tbl[k]) begin
         acc(tbl[k][16], tbl[k][15:8], tbl[k][7:0]);
         if (!tbl[k][16]) chk(r, tbl[k][24:17]);
      end
      for (m = 0; m < 4; m++) begin
         {clk_idle_level, clk_capture_phase} = m[1:0];
         ptx <= 8'h3C + m;
         // idle level only moves while the port is off
         acc(1, 8'h22, 8'h30 | m << 2);
         acc(1, 8'h22, 8'hD0 | m << 2);
         ss_n <= 1'b0;
         acc(1, 8'h21, 8'hA5 ^ m);
         acc(1, 8'h21, 8'h00);
         wirq();
         acc(1, 8'h21, 8'hFF);
         repeat (60) @(posedge MCLK);
         chk(prx, 8'hA5 ^ m);
         acc(0, 8'h23, 0);
         chk(r, 8'hC0);
         acc(0, 8'h21, 0);
         chk(r, 8'h3C + m);
         acc(0, 8'h23, 0);
         chk(r, 8'h00);
         chk({7'h0, IRQ}, 8'h00);
         ss_n <= 1'b1;
      end
      chk({6'h0, SCK_OE, SCK_O}, 8'h03);
      acc(1, 8'h22, 8'hDC);
      SS_N_I <= 1'b0;
      wirq();
      acc(0, 8'h22, 0);
      chk(r, 8'h8C);
      acc(0, 8'h23, 0);
      chk(r, 8'h10);
      SS_N_I <= 1'b1;
      acc(1, 8'h22, 8'h00);
      acc(0, 8'h23, 0);
      chk(r, 8'h00);
      acc(1, 8'h22, 8'h40);
      acc(1, 8'h21, 8'hC3);
      SS_N_I <= 1'b0;
      ext(8'h96);
      chk(r, 8'hC3);
      chk({7'h0, MISO_OE}, 8'h01);
      ext(8'h69);
      acc(0, 8'h23, 0);
      chk(r, 8'hA0);
      acc(0, 8'h21, 0);
      chk(r, 8'h96);
      SS_N_I <= 1'b1;
      foreach (so[k]) begin
         acc(1, 8'h23, so[k][7:0]);
         repeat (3) @(posedge MCLK);
         #1 chk({7'h0, MISO_OE}, {7'h0, so[k][8]});
      end
      summarize();
   end
endmodule
bind scp_core scp_core_chk i_chk (.MCLK, .NRST, .BUS, .RDATA, .IRQ,
   .SCK_O, .SCK_OE, .MOSI_OE, .MISO_OE);
`default_nettype wire
